// [common/link_cfg_pkg.sv]
// constants for the serial link configuration bank
package link_cfg_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_APPLY = 8'h00;
	localparam logic [7:0] OFF_NODE_ADDR = 8'h04;
	localparam logic [7:0] OFF_FRAME_FORMAT = 8'h08;
	localparam logic [7:0] OFF_BAUD_CODE = 8'h0c;
	localparam logic [7:0] OFF_TX_DELAY = 8'h10;
	localparam logic [7:0] OFF_SILENT = 8'h14;
	localparam logic [7:0] OFF_ACTIVE_LINK = 8'h18;
	localparam logic [7:0] OFF_ACTIVE_TIMING = 8'h1c;
	localparam logic [7:0] OFF_REG_QUERY = 8'h20;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FMT_SEVEN_BIT = 3;
	localparam int FMT_MODIFIED_BIT = 2;
	localparam int ACT_FMT_LSB = 8;
	localparam int ACT_BAUD_LSB = 12;
	localparam int ACT_SILENT_LSB = 8;
	localparam int QRY_MENU_LSB = 8;
	localparam int QRY_NUMBER_LSB = 16;

	// ------------------------------------------------------------
	// values after reset and legal ranges
	// ------------------------------------------------------------
	localparam logic [7:0] NODE_ADDR_RESET = 8'h01;
	localparam logic [7:0] NODE_ADDR_MIN = 8'h01;
	localparam logic [7:0] NODE_ADDR_MAX = 8'hf7;
	localparam logic [3:0] FRAME_FORMAT_RESET = 4'h0;
	localparam logic [3:0] BAUD_CODE_RESET = 4'h6;
	localparam logic [3:0] BAUD_CODE_MAX = 4'h9;
	localparam logic [7:0] TX_DELAY_RESET = 8'h02;
	localparam logic [7:0] SILENT_RESET = 8'h00;
	localparam logic [7:0] MS_SETTING_MAX = 8'hfa;

	// stop bits and parity codes in bits 1:0
	localparam logic [1:0] two_stop_code = 2'h0;
	localparam logic [1:0] no_parity_code = 2'h1;
	localparam logic [1:0] even_parity_code = 2'h2;
	localparam logic [1:0] odd_parity_code = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned CLK_FREQ_HZ = 1000000000 / CLK_PERIOD_NS;
	localparam int unsigned ONE_MS_NS = 1000000;
	localparam int unsigned MS_CYCLES = ONE_MS_NS / CLK_PERIOD_NS;
	// bits in one rtu character and twice the idle gap in characters
	localparam int unsigned CHAR_BITS = 11;
	localparam int unsigned IDLE_HALF_CHARS = 7;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hdl/register_number_map.sv]
// maps menu and parameter numbers to a protocol register number
`timescale 1ns/10ps
module register_number_map (
	// selection
	input wire logic modified,
	input wire logic [7:0] menu,
	input wire logic [7:0] param,
	// result
	output logic [15:0] number
);
	logic [15:0] scaled;
	logic [15:0] menuWide;
	logic [15:0] paramWide;

	// menu scaled by 100 or 256, plus parameter, minus one
	assign menuWide = {8'h00, menu};
	assign paramWide = {8'h00, param};
	assign scaled = modified ? {menu, 8'h00} : 16'(menuWide * 16'h0064); // R8
	assign number = 16'(scaled + paramWide - 16'h0001); // R8
endmodule

// [hdl/serial_link_config_bank.sv]
// serial link configuration bank with axi4-lite register access
//
// Contract
// R1 - Writes to node address, format, baud, transmit delay and silent period stay pending until reset or apply.
// R2 - After the active settings are reloaded the apply bit clears itself.
// R3 - Only node addresses 1 to 247 are accepted and the address resets to 1.
// R4 - The link is always a Modbus RTU slave and never starts a transaction.
// R5 - The data-length bit reads 0 and a format selecting seven data bits is refused.
// R6 - The stored format sets the character framing and resets to 8 data, 2 stop, no parity.
// R7 - Format bit 3 is data length, bit 2 register mode and bits 1:0 stop bits and parity.
// R8 - Register numbers are menu times 100 or 256, plus parameter, minus one, by mode.
// R9 - Replies wait at least 1 ms after a request and the transmitter stays on 1 ms after.
// R10 - End of frame is 3.5 characters of idle at zero silent period, else the setting in ms.
`timescale 1ns/10ps
module serial_link_config_bank #(
	parameter int unsigned MS_COUNT = link_cfg_pkg::MS_CYCLES,
	parameter int unsigned CLK_HZ = link_cfg_pkg::CLK_FREQ_HZ
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// active link settings
	output logic [7:0] nodeAddress,
	output logic registerModeModified,
	output logic stopBitsTwo,
	output logic parityEnable,
	output logic parityOdd,
	output logic settingsReloaded,
	// active link timing in clock cycles
	output logic [31:0] bitCycles,
	output logic [31:0] frameIdleCycles,
	output logic [31:0] txEnableDelayCycles,
	output logic [31:0] txStartDelayCycles,
	output logic [31:0] txHoldCycles
);
	import link_cfg_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0] awAddrHeld;
	logic awHeld;
	logic [31:0] wDataHeld;
	logic [3:0] wStrbHeld;
	logic wHeld;
	logic doWrite;
	logic applyBit;
	logic applyWrite;
	logic [7:0] pendAddr;
	logic [3:0] pendFormat;
	logic [3:0] pendBaud;
	logic [7:0] pendTxDelay;
	logic [7:0] pendSilent;
	logic [7:0] actAddr;
	logic [3:0] actFormat;
	logic [3:0] actBaud;
	logic [7:0] actTxDelay;
	logic [7:0] actSilent;
	logic [7:0] queryParam;
	logic [7:0] queryMenu;
	logic [15:0] queryNumber;
	logic [15:0] next_queryNumber;
	logic [31:0] next_bitCycles;
	logic [31:0] readWord;
	logic readMapped;
	logic writeMapped;

	// clock cycles per bit for each baud code
	function automatic logic [31:0] baudCycles(input logic [3:0] code);
		logic [31:0] cycles;
		cycles = 32'(CLK_HZ / 19200);
		unique case (code)
			4'h0: cycles = 32'(CLK_HZ / 300);
			4'h1: cycles = 32'(CLK_HZ / 600);
			4'h2: cycles = 32'(CLK_HZ / 1200);
			4'h3: cycles = 32'(CLK_HZ / 2400);
			4'h4: cycles = 32'(CLK_HZ / 4800);
			4'h5: cycles = 32'(CLK_HZ / 9600);
			4'h6: cycles = 32'(CLK_HZ / 19200);
			4'h7: cycles = 32'(CLK_HZ / 38400);
			4'h8: cycles = 32'(CLK_HZ / 57600);
			4'h9: cycles = 32'(CLK_HZ / 115200);
			default: cycles = 32'(CLK_HZ / 19200);
		endcase
		return cycles;
	endfunction

	// ------------------------------------------------------------
	// axi write channels
	// ------------------------------------------------------------
	// address and data are taken in either order, one write at a time
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld <= 1'b0;
			awAddrHeld <= 8'h00;
			wHeld <= 1'b0;
			wDataHeld <= 32'h00000000;
			wStrbHeld <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddrHeld <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wDataHeld <= s_axi_wdata;
				wStrbHeld <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld <= 1'b0;
			end
		end
	end

	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	assign applyWrite = doWrite && awAddrHeld == OFF_APPLY && wStrbHeld[0] && wDataHeld[0];

	// decode of offsets that answer a write with okay, the read-only active ones included
	always_comb begin
		unique case (awAddrHeld)
			OFF_APPLY, OFF_NODE_ADDR, OFF_FRAME_FORMAT, OFF_BAUD_CODE,
			OFF_TX_DELAY, OFF_SILENT, OFF_REG_QUERY: writeMapped = 1'b1;
			OFF_ACTIVE_LINK, OFF_ACTIVE_TIMING: writeMapped = 1'b1;
			default: writeMapped = 1'b0;
		endcase
	end

	// handshake flags and write response
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce) begin
			s_axi_awready <= !(awHeld || (s_axi_awvalid && s_axi_awready)) || doWrite;
			s_axi_wready <= !(wHeld || (s_axi_wvalid && s_axi_wready)) || doWrite;
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= writeMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// pending settings
	// ------------------------------------------------------------
	// staged values, each setting write checked against its legal range; query menu and parameter taken as written
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pendAddr <= NODE_ADDR_RESET; // R3
			pendFormat <= FRAME_FORMAT_RESET; // R6
			pendBaud <= BAUD_CODE_RESET;
			pendTxDelay <= TX_DELAY_RESET;
			pendSilent <= SILENT_RESET;
			queryParam <= 8'h00;
			queryMenu <= 8'h00;
		end else if (ce && doWrite) begin
			if (awAddrHeld == OFF_NODE_ADDR && wStrbHeld[0] && wDataHeld[31:8] == 24'h000000
				&& wDataHeld[7:0] >= NODE_ADDR_MIN && wDataHeld[7:0] <= NODE_ADDR_MAX) begin
				pendAddr <= wDataHeld[7:0]; // R1 R3
			end
			if (awAddrHeld == OFF_FRAME_FORMAT && wStrbHeld[0] && wDataHeld[31:4] == 28'h0000000
				&& !wDataHeld[FMT_SEVEN_BIT]) begin
				pendFormat <= wDataHeld[3:0]; // R1 R5 R7
			end
			if (awAddrHeld == OFF_BAUD_CODE && wStrbHeld[0] && wDataHeld[31:4] == 28'h0000000
				&& wDataHeld[3:0] <= BAUD_CODE_MAX) begin
				pendBaud <= wDataHeld[3:0]; // R1
			end
			if (awAddrHeld == OFF_TX_DELAY && wStrbHeld[0] && wDataHeld[31:8] == 24'h000000
				&& wDataHeld[7:0] <= MS_SETTING_MAX) begin
				pendTxDelay <= wDataHeld[7:0]; // R1
			end
			if (awAddrHeld == OFF_SILENT && wStrbHeld[0] && wDataHeld[31:8] == 24'h000000
				&& wDataHeld[7:0] <= MS_SETTING_MAX) begin
				pendSilent <= wDataHeld[7:0]; // R1
			end
			if (awAddrHeld == OFF_REG_QUERY) begin
				if (wStrbHeld[0]) begin
					queryParam <= wDataHeld[7:0];
				end
				if (wStrbHeld[1]) begin
					queryMenu <= wDataHeld[QRY_MENU_LSB +: 8];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// apply bit and active settings
	// ------------------------------------------------------------
	// a fresh software set wins over the self clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			applyBit <= 1'b0;
		end else if (ce) begin
			if (applyWrite) begin
				applyBit <= 1'b1;
			end else if (applyBit) begin
				applyBit <= 1'b0; // R2
			end
		end
	end

	// active copy loads at reset and when apply is seen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			actAddr <= NODE_ADDR_RESET; // R1 R3
			actFormat <= FRAME_FORMAT_RESET; // R6
			actBaud <= BAUD_CODE_RESET;
			actTxDelay <= TX_DELAY_RESET;
			actSilent <= SILENT_RESET;
			settingsReloaded <= 1'b0;
		end else if (ce) begin
			settingsReloaded <= applyBit;
			if (applyBit) begin
				actAddr <= pendAddr; // R1
				actFormat <= pendFormat;
				actBaud <= pendBaud;
				actTxDelay <= pendTxDelay;
				actSilent <= pendSilent;
			end
		end
	end

	// ------------------------------------------------------------
	// derived link outputs
	// ------------------------------------------------------------
	assign next_bitCycles = baudCycles(actBaud);

	// framing decoded from the active format code
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nodeAddress <= NODE_ADDR_RESET;
			registerModeModified <= 1'b0;
			stopBitsTwo <= 1'b1; // R6
			parityEnable <= 1'b0;
			parityOdd <= 1'b0;
		end else if (ce) begin
			nodeAddress <= actAddr;
			registerModeModified <= actFormat[FMT_MODIFIED_BIT]; // R7
			stopBitsTwo <= actFormat[1:0] == two_stop_code; // R6 R7
			parityEnable <= actFormat[1:0] == even_parity_code
				|| actFormat[1:0] == odd_parity_code; // R6 R7
			parityOdd <= actFormat[1:0] == odd_parity_code; // R7
		end
	end

	// timing counts; the bank only sets up a slave that answers requests
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bitCycles <= 32'h00000000;
			frameIdleCycles <= 32'h00000000;
			txEnableDelayCycles <= 32'h00000000;
			txStartDelayCycles <= 32'h00000000;
			txHoldCycles <= 32'h00000000;
		end else if (ce) begin // R4
			bitCycles <= next_bitCycles;
			if (actSilent == 8'h00) begin
				frameIdleCycles <= 32'((next_bitCycles * CHAR_BITS * IDLE_HALF_CHARS + 1) / 2); // R10
			end else begin
				frameIdleCycles <= 32'(actSilent * MS_COUNT); // R10
			end
			if (actTxDelay < 8'h02) begin
				txEnableDelayCycles <= 32'(MS_COUNT); // R9
			end else begin
				txEnableDelayCycles <= 32'(actTxDelay * MS_COUNT); // R9
			end
			if (actTxDelay == 8'h00) begin
				txStartDelayCycles <= 32'(MS_COUNT); // R9
			end else if (actTxDelay == 8'h01) begin
				txStartDelayCycles <= 32'(2 * MS_COUNT);
			end else begin
				txStartDelayCycles <= 32'((actTxDelay + 1) * MS_COUNT);
			end
			txHoldCycles <= 32'(MS_COUNT); // R9
		end
	end

	// ------------------------------------------------------------
	// register number lookup
	// ------------------------------------------------------------
	register_number_map numberMap (
		.modified(actFormat[FMT_MODIFIED_BIT]),
		.menu(queryMenu),
		.param(queryParam),
		.number(next_queryNumber)
	);

	// lookup result held for reading
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			queryNumber <= 16'h0000;
		end else if (ce) begin
			queryNumber <= next_queryNumber; // R8
		end
	end

	// ------------------------------------------------------------
	// axi read channel
	// ------------------------------------------------------------
	// read mux; data-length bit always reads zero
	always_comb begin
		readWord = 32'h00000000;
		readMapped = 1'b1;
		unique case (s_axi_araddr)
			OFF_APPLY: readWord = {31'h00000000, applyBit};
			OFF_NODE_ADDR: readWord = {24'h000000, pendAddr};
			OFF_FRAME_FORMAT: readWord = {28'h0000000, 1'b0, pendFormat[2:0]}; // R5
			OFF_BAUD_CODE: readWord = {28'h0000000, pendBaud};
			OFF_TX_DELAY: readWord = {24'h000000, pendTxDelay};
			OFF_SILENT: readWord = {24'h000000, pendSilent};
			OFF_ACTIVE_LINK: readWord = {16'h0000, actBaud, 1'b0, actFormat[2:0], actAddr};
			OFF_ACTIVE_TIMING: readWord = {16'h0000, actSilent, actTxDelay};
			OFF_REG_QUERY: readWord = {queryNumber, queryMenu, queryParam};
			default: readMapped = 1'b0;
		endcase
	end

	// one read at a time, answered the cycle after the address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= readWord;
				s_axi_rresp <= readMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid) begin
				if (s_axi_rready) begin
					s_axi_rvalid <= 1'b0;
					s_axi_arready <= 1'b1;
				end
			end else begin
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// [sim/link_bank_checker_properties.sv]
// assertions on the link configuration bank ports
`timescale 1ns/10ps
module link_bank_checker #(
	parameter int unsigned MS_COUNT = 10
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register bus
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// active settings
	input wire logic [7:0] nodeAddress,
	input wire logic stopBitsTwo,
	input wire logic parityEnable,
	input wire logic parityOdd,
	input wire logic settingsReloaded,
	input wire logic [31:0] txEnableDelayCycles,
	input wire logic [31:0] txStartDelayCycles,
	input wire logic [31:0] txHoldCycles
);
	import link_cfg_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// bus handshakes
	// ------------------------------------------------------------
	AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	AST_WRITE_ORDER: assert property ($rose(s_axi_bvalid) |->
		!$past(s_axi_awready) && !$past(s_axi_wready)) else $error("response before both taken");

	// ------------------------------------------------------------
	// active settings
	// ------------------------------------------------------------
	AST_NODE_RANGE: assert property (nodeAddress >= NODE_ADDR_MIN && nodeAddress <= NODE_ADDR_MAX)
		else $error("node address out of range");
	AST_ACTIVE_HELD: assert property (nodeAddress != $past(nodeAddress) |-> $past(settingsReloaded))
		else $error("active address changed without reload");
	AST_FRAMING: assert property (!(stopBitsTwo && parityEnable) && (!parityOdd || parityEnable))
		else $error("framing outputs inconsistent");
	AST_REPLY_TIMES: assert property (!$past(rst) |-> txHoldCycles == MS_COUNT &&
		txEnableDelayCycles >= MS_COUNT && txStartDelayCycles >= txEnableDelayCycles)
		else $error("reply timing counts wrong");

	// main scenarios
	cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	cover property (settingsReloaded);
	cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind serial_link_config_bank link_bank_checker #(.MS_COUNT(MS_COUNT)) checker_inst (
	.clk(clk), .rst(rst), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.nodeAddress(nodeAddress), .stopBitsTwo(stopBitsTwo), .parityEnable(parityEnable),
	.parityOdd(parityOdd), .settingsReloaded(settingsReloaded),
	.txEnableDelayCycles(txEnableDelayCycles), .txStartDelayCycles(txStartDelayCycles),
	.txHoldCycles(txHoldCycles)
);

// [sim/rtu_host_model.sv]
// behavioural rtu host that follows the bank's active settings
`timescale 1ns/10ps
module rtu_host_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// active settings from the bank
	input wire logic settingsReloaded,
	input wire logic [7:0] nodeAddress,
	input wire logic [31:0] txHoldCycles,
	// host view
	output logic [7:0] targetAddress,
	output logic hostMayTransmit
);
	logic [31:0] quietCount;
	logic reloadSeen;

	// the new address is on the port one cycle after the reload pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reloadSeen <= 1'b0;
		end else begin
			reloadSeen <= settingsReloaded;
		end
	end

	// host addresses the slave at its new address after a reload
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			targetAddress <= 8'h01;
		end else if (reloadSeen) begin
			targetAddress <= nodeAddress;
		end
	end

	// host keeps off the line while the slave holds its transmitter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			quietCount <= 32'h0;
		end else if (settingsReloaded) begin
			quietCount <= txHoldCycles;
		end else if (quietCount != 32'h0) begin
			quietCount <= quietCount - 32'h1;
		end
	end
	assign hostMayTransmit = (quietCount == 32'h0);
endmodule

// [sim/test_serial_link_config_bank.sv]
// self-checking bench for the serial link configuration bank
`timescale 1ns/10ps
`define CHECK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
	$display("unexpected %s expected %h seen %h", what, exp, got); end end
module test_serial_link_config_bank;
	import link_cfg_pkg::*;
	localparam int unsigned MS = 10;
	localparam int unsigned HZ = 1152000;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
	logic [31:0] wData = 32'h0;
	logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
	logic awReady, wReady, bValid, arReady, rValid, modeMod, stopTwo, parEn, parOdd, reloaded;
	logic mayTx;
	logic [1:0] bResp, rResp;
	logic [7:0] nodeAddr, targetAddr;
	logic [31:0] rData, bitCyc, idleCyc, txEnable, txStart, txHold;
	int fails = 0, checked = 0;

	// clock
	always #2 clk = ~clk;

	serial_link_config_bank #(.MS_COUNT(MS), .CLK_HZ(HZ)) uut (
		.clk(clk), .rst(rst), .ce(ce), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.nodeAddress(nodeAddr), .registerModeModified(modeMod), .stopBitsTwo(stopTwo),
		.parityEnable(parEn), .parityOdd(parOdd), .settingsReloaded(reloaded),
		.bitCycles(bitCyc), .frameIdleCycles(idleCyc), .txEnableDelayCycles(txEnable),
		.txStartDelayCycles(txStart), .txHoldCycles(txHold)
	);

	rtu_host_model host (
		.clk(clk), .rst(rst), .settingsReloaded(reloaded), .nodeAddress(nodeAddr),
		.txHoldCycles(txHold), .targetAddress(targetAddr), .hostMayTransmit(mayTx)
	);

	// ------------------------------------------------------------
	// verdict and bus tasks
	// ------------------------------------------------------------
	task automatic complete_run();
		if (fails == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic guard(input int n);
		if (n > 60) begin
			fails++;
			complete_run();
		end
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		while (!done) begin
			@(posedge clk);
			n++;
			guard(n);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
			if (bReady && bValid) begin
				bReady <= 1'b0;
				done = 1'b1;
				`CHECK("bresp", er, bResp)
			end else if (bValid) begin
				bReady <= 1'b1;
			end
		end
	endtask

	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		arAddr <= a;
		arValid <= 1'b1;
		while (!done) begin
			@(posedge clk);
			n++;
			guard(n);
			if (arValid && arReady) arValid <= 1'b0;
			if (rReady && rValid) begin
				rReady <= 1'b0;
				done = 1'b1;
				`CHECK("rdata", ed, rData)
				`CHECK("rresp", er, rResp)
			end else if (rValid) begin
				rReady <= 1'b1;
			end
		end
	endtask

	// sets the apply bit and waits for the reload pulse
	task automatic apply_settings();
		int n;
		n = 0;
		axi_write(OFF_APPLY, 32'h1, RESP_OKAY);
		while (reloaded !== 1'b1) begin
			@(posedge clk);
			n++;
			guard(n);
		end
		@(posedge clk);
		`CHECK("reload pulse", 1'b0, reloaded)
		`CHECK("host quiet", 1'b0, mayTx)
		repeat (MS) @(posedge clk);
		`CHECK("host free", 1'b1, mayTx)
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		axi_read(OFF_APPLY, 32'h0, RESP_OKAY);
		axi_read(OFF_NODE_ADDR, 32'h1, RESP_OKAY);
		axi_read(OFF_FRAME_FORMAT, 32'h0, RESP_OKAY);
		axi_read(OFF_ACTIVE_LINK, 32'h6001, RESP_OKAY);
		axi_read(OFF_ACTIVE_TIMING, 32'h2, RESP_OKAY);
		`CHECK("stop bits", 1'b1, stopTwo)
		`CHECK("parity", 1'b0, parEn)
		`CHECK("idle", (HZ / 19200 * 77 + 1) / 2, idleCyc)
		`CHECK("tx start", 3 * MS, txStart)
		axi_write(8'h24, 32'h5, RESP_SLVERR);
		axi_read(8'h24, 32'h0, RESP_SLVERR);
		// refused values leave the pending copy alone
		axi_write(OFF_NODE_ADDR, 32'h0, RESP_OKAY);
		axi_write(OFF_NODE_ADDR, 32'hf8, RESP_OKAY);
		axi_read(OFF_NODE_ADDR, 32'h1, RESP_OKAY);
		axi_write(OFF_NODE_ADDR, 32'hf7, RESP_OKAY);
		axi_read(OFF_NODE_ADDR, 32'hf7, RESP_OKAY);
		axi_write(OFF_FRAME_FORMAT, 32'h8, RESP_OKAY);
		axi_read(OFF_FRAME_FORMAT, 32'h0, RESP_OKAY);
		axi_write(OFF_BAUD_CODE, 32'h9, RESP_OKAY);
		axi_write(OFF_SILENT, 32'hfb, RESP_OKAY);
		axi_read(OFF_SILENT, 32'h0, RESP_OKAY);
		`CHECK("node held", 8'h01, nodeAddr)
		axi_read(OFF_ACTIVE_LINK, 32'h6001, RESP_OKAY);
		// every stop and parity code in modified register mode
		for (int c = 0; c < 4; c++) begin
			axi_write(OFF_FRAME_FORMAT, 32'h4 | c, RESP_OKAY);
			apply_settings();
			`CHECK("node", 8'hf7, nodeAddr)
			`CHECK("host node", 8'hf7, targetAddr)
			`CHECK("mode", 1'b1, modeMod)
			`CHECK("stop bits", c == 0, stopTwo)
			`CHECK("parity", c >= 2, parEn)
			`CHECK("odd", c == 3, parOdd)
			`CHECK("bit cycles", HZ / 115200, bitCyc)
			axi_read(OFF_APPLY, 32'h0, RESP_OKAY);
		end
		// transmit delay and silent period codes
		for (int k = 0; k < 3; k++) begin
			axi_write(OFF_TX_DELAY, k, RESP_OKAY);
			axi_write(OFF_SILENT, k, RESP_OKAY);
			apply_settings();
			`CHECK("tx enable", (k < 2 ? 1 : k) * MS, txEnable)
			`CHECK("tx start", (k + 1) * MS, txStart)
			`CHECK("idle", (k == 0 ? (HZ / 115200 * 77 + 1) / 2 : k * MS), idleCyc)
		end
		axi_read(OFF_ACTIVE_TIMING, 32'h0202, RESP_OKAY);
		// register number in modified then standard mode
		axi_write(OFF_REG_QUERY, 32'h0305, RESP_OKAY);
		axi_read(OFF_REG_QUERY, 32'h0305 | ((3 * 256 + 5 - 1) << 16), RESP_OKAY);
		axi_write(OFF_FRAME_FORMAT, 32'h0, RESP_OKAY);
		apply_settings();
		axi_read(OFF_REG_QUERY, 32'h0305 | ((3 * 100 + 5 - 1) << 16), RESP_OKAY);
		// second power-up restores the defaults
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHECK("node after reset", 8'h01, nodeAddr)
		axi_read(OFF_NODE_ADDR, 32'h1, RESP_OKAY);
		complete_run();
	end
endmodule
